// ==== pkg/sebt_defines.svh ====
`ifndef SEBT_DEFINES_SVH
`define SEBT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Geometry of the array and the page buffer
// ----------------------------------------------------------------------------
`define SEBT_ADDR_W 14
`define SEBT_PAGE_W 6
`define SEBT_PAGE_LAST 7'h40
`define SEBT_BYTE_LAST 4'h7

// ----------------------------------------------------------------------------
// Fields of the device address word
// ----------------------------------------------------------------------------
`define SEBT_DEV_TYPE_HI 7
`define SEBT_DEV_TYPE_LO 4
`define SEBT_DEV_SEL_HI 3
`define SEBT_DEV_SEL_LO 1
`define SEBT_DEV_RW 0
// Device-type code; this value is arbitrary and is overridden per product.
`define SEBT_TYPE_CODE 4'h5

// ----------------------------------------------------------------------------
// Timing: write cycle length and the system clock period
// ----------------------------------------------------------------------------
`define SEBT_TWC_MS 64'h5
`define SEBT_CLK_PS 64'h1388
`define SEBT_PS_PER_MS 64'h3B9ACA00
`define SEBT_TWC_CYCLES ((`SEBT_TWC_MS * `SEBT_PS_PER_MS) / `SEBT_CLK_PS)

`endif

// ==== pkg/sebt_pkg.sv ====
`include "sebt_defines.svh"

package sebt_pkg;

  // Bus-side states of the target.
  typedef enum logic [2:0] {
    SEBT_IDLE,
    SEBT_RX,
    SEBT_ACK_WAIT,
    SEBT_ACK_DRV,
    SEBT_TX,
    SEBT_TX_ACK,
    SEBT_WAIT
  } sebt_state_t;

  // Which byte of the transfer is being received.
  typedef enum logic [2:0] {
    SEBT_PH_DEV,
    SEBT_PH_AHI,
    SEBT_PH_ALO,
    SEBT_PH_DATA,
    SEBT_PH_READ
  } sebt_phase_t;

  // One write into a byte memory.
  typedef struct packed {
    logic en;
    logic [`SEBT_ADDR_W-1:0] addr;
    logic [7:0] data;
  } sebt_wr_t;

  // Whole state of the target.
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [2:0] sel_m;
    logic [2:0] sel_s;
    logic wp_m;
    logic wp_s;
    sebt_state_t st;
    sebt_phase_t ph;
    logic [3:0] bitcnt;
    logic [7:0] rxsh;
    logic [7:0] txsh;
    logic [`SEBT_ADDR_W-1:0] addr;
    logic [63:0] pvalid;
    logic wr_pend;
    logic busy;
    logic [6:0] ccnt;
    logic [7:0] cpage;
    logic [31:0] ctimer;
    logic ack_ok;
    logic sda_oe;
  } sebt_regs_t;

endpackage

// ==== test/sebt_master_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Two-wire bus master model
// ----------------------------------------
module sebt_master_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // Clock idles high and the data line is released outside frames.
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // One bit: data moves mid low phase, read back at the end of the high phase.
  // change while low
  // Non-blocking updates keep a pin edge that lands on a clock edge race-free.
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    #12;
    sda_oe <= ~b;
    #12;
    scl <= 1'b1;
    #24;
    s = sda;
  endtask

  // A condition: the data line moves with the clock high.
  // The low phase is stretched so the target has let go of an ack first.
  // start and stop
  task automatic cond(input logic is_start);
    scl <= 1'b0;
    #12;
    sda_oe <= ~is_start;
    #36;
    scl <= 1'b1;
    #24;
    sda_oe <= is_start;
    #24;
  endtask

  // Byte out, most significant bit first, then the ninth clock released.
  // eight plus ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask

  // Byte in, then a low acknowledge when more bytes are wanted.
  // master acknowledge
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~more, s);
  endtask
endmodule

// ==== test/sebt_target_tb.sv ====
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module sebt_target_tb;
  import sebt_pkg::*;
  // Type code value is arbitrary.
  localparam logic [3:0] TC = 4'h6;
  localparam logic [2:0] SEL = 3'h5;
  logic clk, reset_n, wp, sda_w, m_oe, d_out, d_oe, busy, scl, a;
  logic [2:0] sel;
  logic [7:0] d;
  int err_total, n_checks;

  // Pull-up: the line is low only while someone pulls it.
  // open drain
  assign sda_w = !(m_oe || (d_oe && !d_out));

  // The write cycle must outlast two polling words, so the busy answer is safe.
  sebt_target #(.WRITE_CYCLES(300), .TYPE_CODE(TC)) sebt_target_inst (
    .clk(clk),
    .reset_n(reset_n),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(d_out),
    .sda_oe(d_oe),
    .hw_select_pins(sel),
    .wp(wp),
    .write_busy(busy)
  );

  sebt_master_model sebt_master_model_inst (
    .scl(scl),
    .sda_oe(m_oe),
    .sda(sda_w)
  );

  // ----------------------------------------
  // Shared bus steps
  // ----------------------------------------
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Start plus device word; a is low when the target answers.
  // word layout
  task automatic dev(input logic rw);
    sebt_master_model_inst.cond(1'b1);
    sebt_master_model_inst.wr_byte({TC, SEL, rw}, a);
  endtask

  task automatic set_addr(input logic [15:0] ad);
    dev(1'b0);
    `CHK(a, 1'b0)
    sebt_master_model_inst.wr_byte(ad[15:8], a);
    `CHK(a, 1'b0)
    sebt_master_model_inst.wr_byte(ad[7:0], a);
    `CHK(a, 1'b0)
  endtask

  // Bounded wait for the write cycle to end; a hang closes the run.
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy === 1'b1; i++)
      @(posedge clk);
    if (busy !== 1'b0)
    begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic read_at(input logic [15:0] ad, input logic [7:0] exp);
    set_addr(ad);
    dev(1'b1);
    `CHK(a, 1'b0)
    sebt_master_model_inst.rd_byte(1'b0, d);
    `CHK(d, exp)
    sebt_master_model_inst.cond(1'b0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Byte write with the top address bits set, then polling while busy.
  task automatic t_write_poll();
    set_addr(16'hC123);
    sebt_master_model_inst.wr_byte(8'h3C, a);
    `CHK(a, 1'b0)
    sebt_master_model_inst.cond(1'b0);
    `CHK(busy, 1'b1)
    dev(1'b0);
    `CHK(a, 1'b1)
    dev(1'b1);
    `CHK(a, 1'b1)
    sebt_master_model_inst.cond(1'b0);
    wait_idle();
    dev(1'b0);
    `CHK(a, 1'b0)
    sebt_master_model_inst.cond(1'b0);
    read_at(16'h0123, 8'h3C);
  endtask

  // Three bytes from offset 3E wrap to the start of the same page.
  task automatic t_page();
    set_addr(16'h013E);
    for (int i = 1; i < 4; i++)
    begin
      sebt_master_model_inst.wr_byte(8'hA0 + 8'(i), a);
      `CHK(a, 1'b0)
    end
    sebt_master_model_inst.cond(1'b0);
    wait_idle();
    read_at(16'h0100, 8'hA3);
    set_addr(16'h013E);
    dev(1'b1);
    sebt_master_model_inst.rd_byte(1'b1, d);
    `CHK(d, 8'hA1)
    sebt_master_model_inst.rd_byte(1'b0, d);
    `CHK(d, 8'hA2)
    sebt_master_model_inst.cond(1'b0);
    dev(1'b0);
    `CHK(a, 1'b0)
    sebt_master_model_inst.cond(1'b0);
  endtask

  // After a refused read byte with no stop the line stays released.
  task automatic t_noack();
    set_addr(16'h013F);
    dev(1'b1);
    sebt_master_model_inst.rd_byte(1'b0, d);
    `CHK(d, 8'hA2)
    sebt_master_model_inst.rd_byte(1'b0, d);
    `CHK(d, 8'hFF)
    sebt_master_model_inst.cond(1'b0);
  endtask

  // Every pin setting against every select code and a wrong type code.
  task automatic t_select();
    for (int p = 0; p < 8; p++)
    begin
      @(posedge clk);
      sel <= 3'(p);
      for (int s = 0; s < 9; s++)
      begin
        sebt_master_model_inst.cond(1'b1);
        sebt_master_model_inst.wr_byte({(s == 8) ? ~TC : TC, 3'(s), 1'b0}, a);
        `CHK(a, (s != p))
        sebt_master_model_inst.cond(1'b0);
      end
    end
    @(posedge clk);
    sel <= SEL;
  endtask

  // Protected array: addresses answered, data refused, nothing written.
  task automatic t_wp();
    @(posedge clk);
    wp <= 1'b1;
    set_addr(16'h0123);
    sebt_master_model_inst.wr_byte(8'h99, a);
    `CHK(a, 1'b1)
    sebt_master_model_inst.cond(1'b0);
    `CHK(busy, 1'b0)
    read_at(16'h0123, 8'h3C);
    @(posedge clk);
    wp <= 1'b0;
  endtask

  // Free-running system clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reset, then the scenarios in turn.
  initial
  begin
    reset_n = 1'b0;
    wp = 1'b0;
    sel = SEL;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_write_poll();
    t_page();
    t_noack();
    t_select();
    t_wp();
    end_sim();
  end
endmodule

// ==== verilog/sebt_mem.sv ====
`timescale 1ns/1ps

// Byte memory with one write port and a registered read port.
module sebt_mem #(
  parameter int AW = 14
) (
  input wire logic clk,
  input sebt_pkg::sebt_wr_t wr,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  import sebt_pkg::*;

  logic [7:0] mem [0:(1 << AW) - 1];

  // No reset on the contents; read data follow the address one cycle late.
  always_ff @(posedge clk)
  begin
    if (wr.en)
    begin
      mem[wr.addr[AW-1:0]] <= wr.data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ==== verilog/sebt_target.sv ====
`timescale 1ns/1ps
`include "sebt_defines.svh"

module sebt_target #(
  parameter int unsigned WRITE_CYCLES = 32'(`SEBT_TWC_CYCLES),
  parameter logic [3:0] TYPE_CODE = `SEBT_TYPE_CODE
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] hw_select_pins,
  input wire logic wp,
  output logic write_busy
);
  import sebt_pkg::*;

  // --------------------------------------------------------------------------
  // State and memories
  // --------------------------------------------------------------------------
  sebt_regs_t r;
  sebt_regs_t n;
  sebt_wr_t buf_wr;
  sebt_wr_t arr_wr;
  logic [7:0] arr_rdata;
  logic [7:0] buf_rdata;
  logic [7:0] byte_in;
  logic [5:0] off_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // The page is gathered in a small buffer and copied to the array only
  // after the stop, so an aborted transfer never touches the array.
  sebt_mem #(.AW(`SEBT_ADDR_W)) u_array (
    .clk(clk),
    .wr(arr_wr),
    .rd_addr(r.addr),
    .rd_data(arr_rdata)
  );

  sebt_mem #(.AW(`SEBT_PAGE_W)) u_page (
    .clk(clk),
    .wr(buf_wr),
    .rd_addr(r.ccnt[5:0]),
    .rd_data(buf_rdata)
  );

  // --------------------------------------------------------------------------
  // Bus events from the synchronised pins
  // --------------------------------------------------------------------------
  // Edges compare the second synchroniser stage with its delayed copy.
  assign scl_rise = r.scl_s && !r.scl_p;
  assign scl_fall = !r.scl_s && r.scl_p;
  assign start_det = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
  assign stop_det = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;
  assign byte_in = {r.rxsh[6:0], r.sda_s};
  assign off_prev = 6'(r.ccnt - 7'h01);

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // One process computes every next value; the bus walk, the commit engine
  // and the synchronisers all live in the one state record.
  always_comb
  begin
    n = r;
    buf_wr = '0;
    arr_wr = '0;
    n.scl_m = scl_in;
    n.scl_s = r.scl_m;
    n.scl_p = r.scl_s;
    n.sda_m = sda_in;
    n.sda_s = r.sda_m;
    n.sda_p = r.sda_s;
    // floating select low
    // A pad pull-down makes an open select pin arrive here as zero.
    n.sel_m = hw_select_pins;
    n.sel_s = r.sel_m;
    n.wp_m = wp;
    n.wp_s = r.wp_m;

    // timed write cycle
    // Copy one buffered byte per cycle, then wait out the fixed time.
    if (r.busy)
    begin
      n.ctimer = r.ctimer + 32'h1;
      if (r.ccnt != `SEBT_PAGE_LAST)
      begin
        n.ccnt = r.ccnt + 7'h01;
      end
      // page offsets written
      // The counter parks at the page end while the buffer read address wraps
      // back to zero, so only the first pass, while the timer still tracks the
      // counter, may write; a late pass would put offset 0 data at offset 63.
      if (r.ccnt != 7'h00 && r.ctimer <= 32'(`SEBT_PAGE_LAST) && r.pvalid[off_prev])
      begin
        arr_wr.en = 1'b1;
        arr_wr.addr = {r.cpage, off_prev};
        arr_wr.data = buf_rdata;
      end
      if (r.ctimer >= WRITE_CYCLES - 32'h1)
      begin
        n.busy = 1'b0;
      end
    end

    if (start_det)
    begin
      n.st = SEBT_RX;
      n.ph = SEBT_PH_DEV;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
      n.wr_pend = 1'b0;
    end
    else if (stop_det)
    begin
      n.st = SEBT_IDLE;
      n.sda_oe = 1'b0;
      n.wr_pend = 1'b0;
      if (r.wr_pend && !r.busy)
      begin
        n.busy = 1'b1;
        n.ccnt = 7'h00;
        n.ctimer = 32'h0;
        n.cpage = r.addr[`SEBT_ADDR_W-1:`SEBT_PAGE_W];
      end
    end
    else
    begin
      unique case (r.st)
        SEBT_IDLE, SEBT_WAIT:
        begin
          n.sda_oe = 1'b0;
        end
        SEBT_RX:
        begin
          if (scl_rise)
          begin
            n.rxsh = byte_in;
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == `SEBT_BYTE_LAST)
            begin
              n.st = SEBT_ACK_WAIT;
              n.ack_ok = 1'b0;
              unique case (r.ph)
                SEBT_PH_DEV:
                begin
                  if (byte_in[`SEBT_DEV_TYPE_HI:`SEBT_DEV_TYPE_LO] == TYPE_CODE &&
                      byte_in[`SEBT_DEV_SEL_HI:`SEBT_DEV_SEL_LO] == r.sel_s &&
                      !r.busy)
                  begin
                    n.ack_ok = 1'b1;
                    n.ph = byte_in[`SEBT_DEV_RW] ? SEBT_PH_READ : SEBT_PH_AHI;
                  end
                end
                SEBT_PH_AHI:
                begin
                  n.addr[`SEBT_ADDR_W-1:8] = byte_in[5:0];
                  n.ack_ok = 1'b1;
                  n.ph = SEBT_PH_ALO;
                end
                SEBT_PH_ALO:
                begin
                  n.addr[7:0] = byte_in;
                  n.ack_ok = 1'b1;
                  n.ph = SEBT_PH_DATA;
                  n.pvalid = '0;
                end
                SEBT_PH_DATA:
                begin
                  if (!r.wp_s)
                  begin
                    n.ack_ok = 1'b1;
                    n.wr_pend = 1'b1;
                    buf_wr.en = 1'b1;
                    buf_wr.addr = {8'h00, r.addr[5:0]};
                    buf_wr.data = byte_in;
                    n.pvalid[r.addr[5:0]] = 1'b1;
                    n.addr[5:0] = r.addr[5:0] + 6'h01;
                  end
                end
                SEBT_PH_READ:
                begin
                  n.ack_ok = 1'b0;
                end
              endcase
            end
          end
        end
        SEBT_ACK_WAIT:
        begin
          if (scl_fall)
          begin
            n.st = r.ack_ok ? SEBT_ACK_DRV : SEBT_WAIT;
            n.sda_oe = r.ack_ok;
          end
        end
        SEBT_ACK_DRV:
        begin
          if (scl_fall)
          begin
            n.bitcnt = 4'h0;
            if (r.ph == SEBT_PH_READ)
            begin
              n.st = SEBT_TX;
              n.txsh = arr_rdata;
              n.sda_oe = ~arr_rdata[7];
            end
            else
            begin
              n.st = SEBT_RX;
              n.sda_oe = 1'b0;
            end
          end
        end
        SEBT_TX:
        begin
          if (scl_fall)
          begin
            if (r.bitcnt == `SEBT_BYTE_LAST)
            begin
              n.st = SEBT_TX_ACK;
              n.sda_oe = 1'b0;
              n.addr = r.addr + 14'h0001;
            end
            else
            begin
              n.bitcnt = r.bitcnt + 4'h1;
              n.txsh = {r.txsh[6:0], 1'b0};
              n.sda_oe = ~r.txsh[6];
            end
          end
        end
        SEBT_TX_ACK:
        begin
          if (scl_rise)
          begin
            n.st = r.sda_s ? SEBT_WAIT : SEBT_ACK_DRV;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = r.sda_oe;
  assign write_busy = r.busy;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  shift_on_fall_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $changed(sda_oe) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("Data line changed without a clock fall or condition.");

  drive_states_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    sda_oe |-> (r.st == SEBT_ACK_DRV || r.st == SEBT_TX) && sda_out == 1'b0)
    else $error("Data line pulled low outside acknowledge or send.");

  start_rx_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    start_det |=> r.st == SEBT_RX && r.bitcnt == 4'h0 && r.ph == SEBT_PH_DEV)
    else $error("Start did not open a device address byte.");

  stop_idle_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    stop_det |=> r.st == SEBT_IDLE && !sda_oe)
    else $error("Stop did not return to standby.");

  stop_launch_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    stop_det && r.wr_pend && !r.busy |=> write_busy && r.ctimer == 32'h0)
    else $error("Stop after write data did not start the write cycle.");

  busy_nack_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    r.busy && r.st == SEBT_RX && r.ph == SEBT_PH_DEV && scl_rise &&
    r.bitcnt == 4'h7 |=> !r.ack_ok ##1 !sda_oe [*2])
    else $error("Address word acknowledged during the write cycle.");

  protect_nack_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    r.st == SEBT_RX && r.ph == SEBT_PH_DATA && r.wp_s && scl_rise &&
    r.bitcnt == 4'h7 |=> !r.ack_ok && !r.wr_pend)
    else $error("Protected data byte was acknowledged.");

  wc_bound_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    write_busy |-> r.ctimer < WRITE_CYCLES)
    else $error("Write cycle ran past its limit.");

  tx_release_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    r.st == SEBT_TX_ACK || r.st == SEBT_WAIT |-> !sda_oe)
    else $error("Data line held while the master answers.");

  read_next_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    r.st == SEBT_TX && scl_fall && r.bitcnt == 4'h7 && !start_det && !stop_det
    |=> r.addr == $past(r.addr) + 14'h0001)
    else $error("Read address did not advance after a byte.");

endmodule
